// >>> lic_ctl_if.sv
// interface between the register file and the hook timer
`timescale 1ns/100ps
interface lic_ctl_if;
  logic [1:0] cnt_sel;
  logic [1:0] line_req;
  logic req_valid;
  logic [1:0] line_state;
  logic timer_done;
  modport regs (output cnt_sel, output line_req, output req_valid, input line_state, input timer_done);
  modport timer (input cnt_sel, input line_req, input req_valid, output line_state, output timer_done);
endinterface : lic_ctl_if

// >>> lic_hook_timer.sv
// off-hook counter and line state sequencer
`timescale 1ns/100ps
module lic_hook_timer #(
  parameter int C512 = lic_pkg::LIC_C512,
  parameter int C128 = lic_pkg::LIC_C128,
  parameter int C64 = lic_pkg::LIC_C64,
  parameter int C8 = lic_pkg::LIC_C8
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_pd,
  lic_ctl_if.timer ctl
);
  import lic_pkg::*;

  // ==========================================================
  // counter length decode
  function automatic logic [31:0] cnt_len(input logic [1:0] sel);
    case (sel)
      LIC_CNT_512: cnt_len = 32'(C512);
      LIC_CNT_128: cnt_len = 32'(C128);
      LIC_CNT_64: cnt_len = 32'(C64);
      default: cnt_len = 32'(C8);
    endcase
  endfunction : cnt_len

  lic_hook_state_t state;
  lic_hook_state_t next_state;
  logic [31:0] count;
  logic [31:0] next_count;
  logic done;
  logic next_done;

  // next-state: off-hook request runs the counter before the line is reported off-hook
  always_comb begin
    next_state = state;
    next_count = count;
    next_done = 1'b0;
    case (state)
      LIC_HS_ON: begin
        if (ctl.req_valid && ctl.line_req == LIC_LINE_OFF) begin
          next_state = LIC_HS_WAIT;
          next_count = cnt_len(ctl.cnt_sel);
        end else if (ctl.req_valid && ctl.line_req == LIC_LINE_MON) begin
          next_state = LIC_HS_MON;
        end
      end
      LIC_HS_WAIT: begin
        if (ctl.req_valid && ctl.line_req == LIC_LINE_ON) begin
          next_state = LIC_HS_ON;
        end else if (count <= 32'h0000_0001) begin
          next_state = LIC_HS_OFF;
          next_done = 1'b1;
        end else begin
          next_count = count - 32'h0000_0001;
        end
      end
      LIC_HS_OFF: begin
        if (ctl.req_valid && ctl.line_req == LIC_LINE_ON) next_state = LIC_HS_ON;
        else if (ctl.req_valid && ctl.line_req == LIC_LINE_MON) next_state = LIC_HS_MON;
      end
      default: begin
        if (ctl.req_valid && ctl.line_req == LIC_LINE_ON) next_state = LIC_HS_ON;
        else if (ctl.req_valid && ctl.line_req == LIC_LINE_OFF) begin
          next_state = LIC_HS_WAIT;
          next_count = cnt_len(ctl.cnt_sel);
        end
      end
    endcase
    // power-down drops the line back on-hook
    if (i_pd) begin
      next_state = LIC_HS_ON;
      next_done = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= LIC_HS_ON;
      count <= 32'h0000_0000;
      done <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      done <= next_done;
    end
  end

  // reported line state; wait still reads on-hook until the counter expires
  always_comb begin
    case (state)
      LIC_HS_OFF: ctl.line_state = LIC_LINE_OFF;
      LIC_HS_MON: ctl.line_state = LIC_LINE_MON;
      default: ctl.line_state = LIC_LINE_ON;
    endcase
  end
  assign ctl.timer_done = done;
endmodule : lic_hook_timer

// >>> lic_line_regs.sv
// line interface control register bank: hook, power, link status, interrupts
//
// Contract
// - off-hook counter select: 00=512 ms, 01=128 ms, 10=64 ms, 11=8 ms
// - counter select resets to the 128 ms setting
// - line state: 00 on-hook, 01 off-hook, 10 monitor; 11 reserved
// - internal controller updates line state without host writes
// - billing tone detected flag sets only when enabled; enable resets to 0
// - device power-down bit 1 powers down whole device, 0 normal
// - line-side power-down bit 1 puts line-side chip in low power
// - voltage reading forced to zero at 3 V or less unless disabled
// - hybrid transmit path connected when bit is 1, disconnected at 0
// - frame lock bit reads 1 with lock, 0 without
`timescale 1ns/100ps
module lic_line_regs #(
  parameter int C512 = lic_pkg::LIC_C512,
  parameter int C128 = lic_pkg::LIC_C128,
  parameter int C64 = lic_pkg::LIC_C64,
  parameter int C8 = lic_pkg::LIC_C8
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [1:0] i_ctrl_line_req,
  input wire logic i_ctrl_line_req_valid,
  input wire logic i_billing_tone,
  input wire logic i_frame_lock,
  input wire logic [7:0] i_line_voltage,
  output logic [1:0] o_line_state_select,
  output logic o_offhook_done,
  output logic o_device_power_down,
  output logic o_line_side_power_down,
  output logic o_hybrid_transmit_connect,
  output logic [7:0] o_line_voltage_reading,
  output logic o_irq
);
  import lic_pkg::*;

  // ==========================================================
  // pin synchronisers: line-side inputs cross from the isolation link
  logic [1:0] bt_sync;
  logic [1:0] lock_sync;
  logic [7:0] lv_meta;
  logic [7:0] lv_sync;
  logic [1:0] next_bt_sync;
  logic [1:0] next_lock_sync;

  always_comb begin
    next_bt_sync = {bt_sync[0], i_billing_tone};
    next_lock_sync = {lock_sync[0], i_frame_lock};
  end

  // only bit 1 of each pair is read by logic; multi-bit voltage is a slow level
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bt_sync <= 2'b00;
      lock_sync <= 2'b00;
      lv_meta <= LIC_ZERO8;
      lv_sync <= LIC_ZERO8;
    end else begin
      bt_sync <= next_bt_sync;
      lock_sync <= next_lock_sync;
      lv_meta <= i_line_voltage;
      lv_sync <= lv_meta;
    end
  end

  // ==========================================================
  // registers
  logic [1:0] cnt_sel;
  logic [1:0] next_cnt_sel;
  logic [1:0] host_line;
  logic [1:0] next_host_line;
  logic host_line_valid;
  logic next_host_line_valid;
  logic [7:0] pwr;
  logic [7:0] next_pwr;
  logic [7:0] irq_status;
  logic [7:0] next_irq_status;
  logic [7:0] irq_mask;
  logic [7:0] next_irq_mask;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic lock_prev;
  logic [7:0] lv_out;
  logic [7:0] next_lv_out;
  logic [7:0] events;

  lic_ctl_if ctl ();

  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    hit = (a == target);
  endfunction : hit

  // hook timer: internal controller requests have priority over host writes
  assign ctl.cnt_sel = cnt_sel;
  assign ctl.line_req = i_ctrl_line_req_valid ? i_ctrl_line_req : host_line;
  assign ctl.req_valid = i_ctrl_line_req_valid | host_line_valid;

  lic_hook_timer #(
    .C512(C512),
    .C128(C128),
    .C64(C64),
    .C8(C8)
  ) u_timer (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_pd(pwr[LIC_PWR_DEV_PD]),
    .ctl(ctl.timer)
  );

  // events: billing tone when enabled, lock change, off-hook counter expiry
  always_comb begin
    events = LIC_ZERO8;
    events[LIC_IRQ_BTD] = bt_sync[1] & pwr[LIC_PWR_BT_EN];
    events[LIC_IRQ_LOCK] = lock_sync[1] ^ lock_prev;
    events[LIC_IRQ_HOOK] = ctl.timer_done;
  end

  // register writes; reserved line-state code 11 is ignored
  always_comb begin
    next_cnt_sel = cnt_sel;
    next_host_line = host_line;
    next_host_line_valid = 1'b0;
    next_pwr = pwr;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (i_wr) begin
      if (hit(i_addr, LIC_ADDR_HOOK)) begin
        next_cnt_sel = i_wdata[LIC_HOOK_CNT_LSB +: 2];
        if (i_wdata[LIC_HOOK_LINE_LSB +: 2] != LIC_LINE_RSV) begin
          next_host_line = i_wdata[LIC_HOOK_LINE_LSB +: 2];
          next_host_line_valid = 1'b1;
        end
      end else if (hit(i_addr, LIC_ADDR_POWER)) begin
        // reserved bits keep their stored value whatever is written
        next_pwr = (i_wdata & LIC_PWR_RW_MASK) | (pwr & LIC_PWR_KEEP_MASK);
      end else if (hit(i_addr, LIC_ADDR_IRQ_STATUS)) begin
        next_irq_status = irq_status & ~i_wdata;
      end else if (hit(i_addr, LIC_ADDR_IRQ_MASK)) begin
        next_irq_mask = i_wdata & LIC_IRQ_MASK_BITS;
      end
    end
    // set wins over clear in the same cycle
    next_irq_status = next_irq_status | events;
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    next_rdata = rdata;
    if (i_rd) begin
      if (hit(i_addr, LIC_ADDR_HOOK)) begin
        next_rdata = LIC_ZERO8;
        next_rdata[LIC_HOOK_CNT_LSB +: 2] = cnt_sel;
        next_rdata[LIC_HOOK_LINE_LSB +: 2] = ctl.line_state;
      end else if (hit(i_addr, LIC_ADDR_POWER)) begin
        next_rdata = pwr;
      end else if (hit(i_addr, LIC_ADDR_LINK)) begin
        next_rdata = LIC_ZERO8;
        next_rdata[LIC_LINK_LOCK] = lock_sync[1];
      end else if (hit(i_addr, LIC_ADDR_IRQ_STATUS)) begin
        next_rdata = irq_status;
      end else if (hit(i_addr, LIC_ADDR_IRQ_MASK)) begin
        next_rdata = irq_mask;
      end else if (hit(i_addr, LIC_ADDR_VOLTAGE)) begin
        next_rdata = lv_out;
      end else begin
        next_rdata = LIC_ZERO8;
      end
    end
  end

  // voltage forcing to zero at or below the threshold unless disabled
  always_comb begin
    if (!pwr[LIC_PWR_LV_FD] && lv_sync <= LIC_LV_THRESH) next_lv_out = LIC_ZERO8;
    else next_lv_out = lv_sync;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_sel <= LIC_HOOK_RESET[LIC_HOOK_CNT_LSB +: 2];
      host_line <= LIC_LINE_ON;
      host_line_valid <= 1'b0;
      pwr <= LIC_PWR_RESET;
      irq_status <= LIC_ZERO8;
      irq_mask <= LIC_ZERO8;
      rdata <= LIC_ZERO8;
      lock_prev <= 1'b0;
      lv_out <= LIC_ZERO8;
    end else begin
      cnt_sel <= next_cnt_sel;
      host_line <= next_host_line;
      host_line_valid <= next_host_line_valid;
      pwr <= next_pwr;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
      lock_prev <= lock_sync[1];
      lv_out <= next_lv_out;
    end
  end

  // ==========================================================
  // outputs
  assign o_rdata = rdata;
  assign o_line_state_select = ctl.line_state;
  assign o_offhook_done = ctl.timer_done;
  assign o_device_power_down = pwr[LIC_PWR_DEV_PD];
  assign o_line_side_power_down = pwr[LIC_PWR_LINE_PD];
  assign o_hybrid_transmit_connect = pwr[LIC_PWR_HYB];
  assign o_line_voltage_reading = lv_out;
  assign o_irq = |(irq_status & irq_mask);
endmodule : lic_line_regs

// >>> lic_line_regs_bench.sv
// self-checking bench for the line interface control register bank
`timescale 1ns/100ps
module lic_line_regs_bench;
  import lic_pkg::*;
  // short counts keep each off-hook wait to a few dozen cycles
  localparam int CNT [4] = '{40, 10, 5, 2};
  logic i_clock = 1'b0;
  logic i_rst_n;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [1:0] i_ctrl_line_req;
  logic i_ctrl_line_req_valid;
  logic i_billing_tone, i_frame_lock, o_offhook_done, o_device_power_down;
  logic o_line_side_power_down, o_hybrid_transmit_connect, o_irq;
  logic [7:0] i_line_voltage, o_rdata, o_line_voltage_reading;
  logic [1:0] o_line_state_select;
  int errors = 0;
  int checks = 0;
  always #2 i_clock = ~i_clock;
  lic_line_regs #(.C512(CNT[0]), .C128(CNT[1]), .C64(CNT[2]), .C8(CNT[3])) u_dut (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_ctrl_line_req(i_ctrl_line_req),
    .i_ctrl_line_req_valid(i_ctrl_line_req_valid),
    .i_billing_tone(i_billing_tone),
    .i_frame_lock(i_frame_lock),
    .i_line_voltage(i_line_voltage),
    .o_line_state_select(o_line_state_select),
    .o_offhook_done(o_offhook_done),
    .o_device_power_down(o_device_power_down),
    .o_line_side_power_down(o_line_side_power_down),
    .o_hybrid_transmit_connect(o_hybrid_transmit_connect),
    .o_line_voltage_reading(o_line_voltage_reading),
    .o_irq(o_irq)
  );
  lic_line_side_model u_line (.i_clock(i_clock), .i_low_power(o_line_side_power_down),
    .o_billing_tone(i_billing_tone), .o_frame_lock(i_frame_lock), .o_line_voltage(i_line_voltage));
  // ==========================================================
  // bus and compare helpers
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    // step off the edge so callers see the written outputs settled
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(n, d, e);
  endtask : rc
  task automatic wt(input int c);
    repeat (c) @(posedge i_clock);
    #1;
  endtask : wt
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rc("hook", LIC_ADDR_HOOK, 8'h40);
    rc("power", LIC_ADDR_POWER, 8'h00);
    rc("unmapped", 4'hF, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_power;
    logic [7:0] d;
    rc("lock", LIC_ADDR_LINK, 8'h08);
    rd(LIC_ADDR_POWER, d);
    wr(LIC_ADDR_POWER, d | 8'hF4); // reserved bits go back as read
    rc("power set", LIC_ADDR_POWER, 8'hF4);
    chk("pd outs", {5'h00, o_device_power_down, o_line_side_power_down, o_hybrid_transmit_connect}, 8'h07);
    wt(6);
    rc("lock lost", LIC_ADDR_LINK, 8'h00);
    rd(LIC_ADDR_POWER, d);
    // the model runs from the bench clock, so no clock setup precedes this
    wr(LIC_ADDR_POWER, d & 8'h0B);
    chk("pd clear", {5'h00, o_device_power_down, o_line_side_power_down, o_hybrid_transmit_connect}, 8'h00);
    wt(6);
    rc("lock back", LIC_ADDR_LINK, 8'h08);
    $display("test power done");
  endtask : t_power
  task automatic t_hook;
    int n;
    for (int s = 0; s < 4; s++) begin
      wr(LIC_ADDR_HOOK, {s[1:0], 6'h01});
      n = 0;
      while (o_line_state_select !== LIC_LINE_OFF && n < 600) begin
        @(posedge i_clock);
        n++;
      end
      chk("offhook wait", 8'(n >= CNT[s] && n <= CNT[s] + 2), 8'h01);
      chk("expiry pulse", {7'h00, o_offhook_done}, 8'h01);
      wr(LIC_ADDR_HOOK, {s[1:0], 6'h03}); // reserved code only moves the counter select
      rc("hook rsv", LIC_ADDR_HOOK, {s[1:0], 6'h01});
      wr(LIC_ADDR_HOOK, {s[1:0], 6'h00});
      rc("onhook", LIC_ADDR_HOOK, {s[1:0], 6'h00});
    end
    wr(LIC_ADDR_HOOK, 8'h42);
    rc("monitor", LIC_ADDR_HOOK, 8'h42);
    wr(LIC_ADDR_HOOK, 8'h40);
    $display("test hook done");
  endtask : t_hook
  task automatic t_ctrl;
    @(posedge i_clock);
    i_ctrl_line_req <= 2'h2;
    i_ctrl_line_req_valid <= 1'b1;
    @(posedge i_clock);
    i_ctrl_line_req_valid <= 1'b0;
    wt(3);
    chk("ctrl mon", {6'h00, o_line_state_select}, 8'h02);
    wr(LIC_ADDR_POWER, 8'h40);
    wt(4);
    chk("pd onhook", {6'h00, o_line_state_select}, 8'h00);
    wr(LIC_ADDR_POWER, 8'h00);
    $display("test ctrl done");
  endtask : t_ctrl
  task automatic t_tone;
    wr(LIC_ADDR_IRQ_STATUS, 8'h07);
    u_line.set_tone(1'b1);
    wt(6);
    rc("tone off", LIC_ADDR_IRQ_STATUS, 8'h00);
    wr(LIC_ADDR_POWER, 8'h80);
    wr(LIC_ADDR_IRQ_MASK, 8'h01);
    wt(4);
    chk("irq on", {7'h00, o_irq}, 8'h01);
    rc("tone on", LIC_ADDR_IRQ_STATUS, 8'h01);
    wr(LIC_ADDR_IRQ_MASK, 8'h00);
    wt(1);
    chk("irq masked", {7'h00, o_irq}, 8'h00);
    u_line.set_tone(1'b0);
    wr(LIC_ADDR_POWER, 8'h00);
    wt(4);
    wr(LIC_ADDR_IRQ_STATUS, 8'h01);
    rc("tone clr", LIC_ADDR_IRQ_STATUS, 8'h00);
    $display("test tone done");
  endtask : t_tone
  task automatic t_volt;
    u_line.set_volt(8'h03);
    wt(6);
    chk("volt 3", o_line_voltage_reading, 8'h00);
    u_line.set_volt(8'h04);
    wt(6);
    chk("volt 4", o_line_voltage_reading, 8'h04);
    wr(LIC_ADDR_POWER, 8'h10);
    u_line.set_volt(8'h02);
    wt(6);
    chk("volt 2", o_line_voltage_reading, 8'h02);
    wr(LIC_ADDR_POWER, 8'h00);
    $display("test volt done");
  endtask : t_volt
  // ==========================================================
  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    i_rst_n = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_ctrl_line_req = 2'h0;
    i_ctrl_line_req_valid = 1'b0;
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_reset;
    t_power;
    t_hook;
    t_ctrl;
    t_tone;
    t_volt;
    end_sim;
  end
  // the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clock);
    errors++;
    end_sim;
  end
endmodule : lic_line_regs_bench

// >>> lic_line_regs_chk.sv
// port-level checks for the line interface control register bank
`timescale 1ns/100ps
module lic_line_regs_chk
  import lic_pkg::*;
#(
  parameter int C512 = LIC_C512,
  parameter int C128 = LIC_C128,
  parameter int C64 = LIC_C64,
  parameter int C8 = LIC_C8
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_frame_lock,
  input wire logic [7:0] i_line_voltage,
  input wire logic [1:0] o_line_state_select,
  input wire logic o_offhook_done,
  input wire logic o_device_power_down,
  input wire logic o_line_side_power_down,
  input wire logic o_hybrid_transmit_connect,
  input wire logic [7:0] o_line_voltage_reading,
  input wire logic o_irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // cycles since reset: synchroniser history is stale before 7
  logic [2:0] up;
  logic [2:0] next_up;
  always_comb next_up = (up == 3'h7) ? up : up + 3'h1;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) up <= 3'h0;
    else up <= next_up;
  end
  wire logic ok = (up == 3'h7);
  wire logic pwr_wr = i_wr && (i_addr == LIC_ADDR_POWER);
  // ==========================================================
  property p_dev_pd;
    pwr_wr |=> o_device_power_down == $past(i_wdata[LIC_PWR_DEV_PD]);
  endproperty
  a_dev_pd: assert property (p_dev_pd) else $error("device power-down bit not taken");
  property p_pd_hook;
    o_device_power_down [*3] |-> o_line_state_select == LIC_LINE_ON;
  endproperty
  a_pd_hook: assert property (p_pd_hook) else $error("power-down left line off-hook");
  property p_line_pd;
    pwr_wr |=> o_line_side_power_down == $past(i_wdata[LIC_PWR_LINE_PD]);
  endproperty
  a_line_pd: assert property (p_line_pd) else $error("line-side power-down not taken");
  property p_hyb;
    pwr_wr |=> o_hybrid_transmit_connect == $past(i_wdata[LIC_PWR_HYB]);
  endproperty
  a_hyb: assert property (p_hyb) else $error("hybrid connect bit not taken");
  property p_no_rsv;
    o_line_state_select != LIC_LINE_RSV;
  endproperty
  a_no_rsv: assert property (p_no_rsv) else $error("reserved line state shown");
  property p_done;
    o_offhook_done |=> !o_offhook_done && o_line_state_select == LIC_LINE_OFF;
  endproperty
  a_done: assert property (p_done) else $error("off-hook expiry pulse wrong");
  property p_mask;
    i_wr && i_addr == LIC_ADDR_IRQ_MASK && i_wdata[2:0] == 3'h0 |=> !o_irq;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt high with mask clear");
  property p_volt;
    (ok && $stable(i_line_voltage)) [*4] ##0 (i_line_voltage > LIC_LV_THRESH)
      |=> o_line_voltage_reading == $past(i_line_voltage);
  endproperty
  a_volt: assert property (p_volt) else $error("voltage reading above threshold wrong");
  property p_lock;
    (ok && $stable(i_frame_lock)) [*4] ##0 (i_rd && i_addr == LIC_ADDR_LINK)
      |=> o_rdata[LIC_LINK_LOCK] == $past(i_frame_lock);
  endproperty
  a_lock: assert property (p_lock) else $error("frame lock bit wrong");
endmodule : lic_line_regs_chk
bind lic_line_regs lic_line_regs_chk #(.C512(C512), .C128(C128), .C64(C64), .C8(C8)) u_chk (
  .i_clock(i_clock),
  .i_rst_n(i_rst_n),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .i_frame_lock(i_frame_lock),
  .i_line_voltage(i_line_voltage),
  .o_line_state_select(o_line_state_select),
  .o_offhook_done(o_offhook_done),
  .o_device_power_down(o_device_power_down),
  .o_line_side_power_down(o_line_side_power_down),
  .o_hybrid_transmit_connect(o_hybrid_transmit_connect),
  .o_line_voltage_reading(o_line_voltage_reading),
  .o_irq(o_irq)
);

// >>> lic_line_side_model.sv
// behavioural model of the isolated line-side chip
`timescale 1ns/100ps
module lic_line_side_model (
  input wire logic i_clock,
  input wire logic i_low_power,
  output logic o_billing_tone,
  output logic o_frame_lock,
  output logic [7:0] o_line_voltage
);
  logic tone_req = 1'b0;
  logic [7:0] volt_req = 8'h00;
  // ==========================================================
  // hooks the bench calls to change the line conditions
  task automatic set_tone(input logic v);
    tone_req = v;
  endtask : set_tone
  task automatic set_volt(input logic [7:0] v);
    volt_req = v;
  endtask : set_volt
  // in low power the chip loses frame lock and stops tone detection
  always @(posedge i_clock) begin
    o_frame_lock <= !i_low_power;
    o_billing_tone <= tone_req && !i_low_power;
    o_line_voltage <= volt_req;
  end
endmodule : lic_line_side_model

// >>> lic_pkg.sv
// package of constants and types for the line interface control register bank
package lic_pkg;
  // ==========================================================
  // register offsets (plain port, 8-bit registers)
  localparam logic [3:0] LIC_ADDR_HOOK = 4'h0;
  localparam logic [3:0] LIC_ADDR_POWER = 4'h1;
  localparam logic [3:0] LIC_ADDR_LINK = 4'h2;
  localparam logic [3:0] LIC_ADDR_IRQ_STATUS = 4'h3;
  localparam logic [3:0] LIC_ADDR_IRQ_MASK = 4'h4;
  localparam logic [3:0] LIC_ADDR_VOLTAGE = 4'h5;
  // ==========================================================
  // field positions
  localparam int LIC_HOOK_CNT_LSB = 6;
  localparam int LIC_HOOK_LINE_LSB = 0;
  localparam int LIC_PWR_BT_EN = 7;
  localparam int LIC_PWR_DEV_PD = 6;
  localparam int LIC_PWR_LINE_PD = 5;
  localparam int LIC_PWR_LV_FD = 4;
  localparam int LIC_PWR_HYB = 2;
  localparam int LIC_LINK_LOCK = 3;
  localparam int LIC_IRQ_BTD = 0;
  localparam int LIC_IRQ_LOCK = 1;
  localparam int LIC_IRQ_HOOK = 2;
  // ==========================================================
  // reset values and masks
  localparam logic [7:0] LIC_HOOK_RESET = 8'h40;
  localparam logic [7:0] LIC_PWR_RESET = 8'h00;
  localparam logic [7:0] LIC_PWR_RW_MASK = 8'hF4;
  localparam logic [7:0] LIC_PWR_KEEP_MASK = 8'h0B;
  localparam logic [7:0] LIC_IRQ_MASK_BITS = 8'h07;
  localparam logic [7:0] LIC_ZERO8 = 8'h00;
  // ==========================================================
  // times and derived counts at 250 MHz
  localparam int LIC_CLK_MHZ = 250;
  localparam int LIC_T512_MS = 512;
  localparam int LIC_T128_MS = 128;
  localparam int LIC_T64_MS = 64;
  localparam int LIC_T8_MS = 8;
  localparam int LIC_C512 = LIC_T512_MS * 1000 * LIC_CLK_MHZ;
  localparam int LIC_C128 = LIC_T128_MS * 1000 * LIC_CLK_MHZ;
  localparam int LIC_C64 = LIC_T64_MS * 1000 * LIC_CLK_MHZ;
  localparam int LIC_C8 = LIC_T8_MS * 1000 * LIC_CLK_MHZ;
  // line voltage threshold: 3 V expressed in reading lsbs (1 V per lsb)
  localparam logic [7:0] LIC_LV_THRESH = 8'h03;
  // ==========================================================
  typedef enum logic [1:0] {
    LIC_CNT_512 = 2'b00,
    LIC_CNT_128 = 2'b01,
    LIC_CNT_64 = 2'b10,
    LIC_CNT_8 = 2'b11
  } lic_cnt_sel_t;
  typedef enum logic [1:0] {
    LIC_LINE_ON = 2'b00,
    LIC_LINE_OFF = 2'b01,
    LIC_LINE_MON = 2'b10,
    LIC_LINE_RSV = 2'b11
  } lic_line_t;
  // hook sequencer, gray coded along on-hook -> wait -> off-hook
  typedef enum logic [1:0] {
    LIC_HS_ON = 2'b00,
    LIC_HS_WAIT = 2'b01,
    LIC_HS_OFF = 2'b11,
    LIC_HS_MON = 2'b10
  } lic_hook_state_t;
endpackage : lic_pkg
